// file: bench/light_host.sv
// host model driving the byte-wide register port
`timescale 1ns/1ps
module light_host (
	// clock
	input  wire logic       CLK,
	// register port
	output logic            PTR_WR,
	output logic [7:0]      PTR_DATA,
	output logic            WR_STB,
	output logic [7:0]      WR_DATA,
	output logic            RD_STB,
	input  wire logic [7:0] RD_DATA,
	input  wire logic       RD_VALID
);
	// idle port at time zero
	initial begin
		{PTR_WR, WR_STB, RD_STB} = 3'h0;
		{PTR_DATA, WR_DATA} = 16'h0;
	end
	// pointer load, lines turned over once released
	task automatic pulse_ptr(input logic [7:0] p);
		@(posedge CLK) #1;
		PTR_WR = 1'b1;
		PTR_DATA = p;
		@(posedge CLK) #1;
		PTR_WR = 1'b0;
		PTR_DATA = ~p;
	endtask
	// range codes 13..15 are never issued by callers
	task automatic wr16(input logic [7:0] p, input logic [15:0] v);
		pulse_ptr(p);
		WR_STB = 1'b1;
		WR_DATA = v[15:8]; // msb byte first
		@(posedge CLK) #1;
		WR_DATA = v[7:0];
		@(posedge CLK) #1;
		WR_STB = 1'b0;
		WR_DATA = ~v[7:0];
	endtask
	// two back-to-back read strobes, msb then lsb
	task automatic rd16(input logic [7:0] p, output logic [15:0] v);
		v = 16'h0;
		pulse_ptr(p);
		RD_STB = 1'b1;
		repeat (2) begin
			@(posedge CLK) #1;
			v = (RD_VALID === 1'b1) ? {v[7:0], RD_DATA} : 16'hxxxx;
		end
		RD_STB = 1'b0;
	endtask
endmodule

// file: bench/light_regs_tb_top.sv
// self-checking bench for the result and setup register block
`timescale 1ns/1ps
module light_regs_tb_top;
	logic        clk, reset_n, ptr_wr, wr_stb, rd_stb, rd_valid;
	logic        adc_overload, converting;
	logic [7:0]  ptr_data, wr_data, rd_data;
	logic [11:0] adc_mantissa;
	logic [3:0]  range_out, rv;
	logic [15:0] cfg;
	int          bad_count, n_tests, cyc, n;
	localparam int SHORT_T = 8;
	localparam int LONG_T  = 20;
	// dut with short conversion slices
	light_regs #(.SHORT_CYCLES(SHORT_T), .LONG_CYCLES(LONG_T)) light_regs_inst (
		.CLK(clk), .RESET_N(reset_n), .PTR_WR(ptr_wr), .PTR_DATA(ptr_data),
		.WR_STB(wr_stb), .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data),
		.RD_VALID(rd_valid), .ADC_MANTISSA(adc_mantissa), .ADC_OVERLOAD(adc_overload),
		.RANGE_OUT(range_out), .CONVERTING(converting));
	light_host light_host_inst (
		.CLK(clk), .PTR_WR(ptr_wr), .PTR_DATA(ptr_data), .WR_STB(wr_stb),
		.WR_DATA(wr_data), .RD_STB(rd_stb), .RD_DATA(rd_data), .RD_VALID(rd_valid));
	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] p, input logic [15:0] e);
		logic [15:0] v;
		light_host_inst.rd16(p, v);
		check(v, e);
	endtask
	// bounded wait for the converting flag
	task automatic wait_conv(input logic lvl, input int lim);
		int k;
		k = 0;
		while (converting !== lvl && k < lim) begin
			@(posedge clk) #1;
			k++;
		end
		check({15'h0, converting}, {15'h0, lvl});
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			print_verdict();
		end
	end
	initial begin
		reset_n = 1'b0;
		adc_mantissa = 12'h000;
		adc_overload = 1'b0;
		repeat (20) @(posedge clk);
		#1 reset_n = 1'b1;
		rd_chk(light_pkg::PTR_SETUP, 16'hc810);
		light_host_inst.wr16(light_pkg::PTR_RESULT, 16'hffff);
		rd_chk(light_pkg::PTR_RESULT, 16'h0000);
		rd_chk(8'h05, 16'h0000);
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'hc9e0);
		rd_chk(light_pkg::PTR_SETUP, 16'hc800);
		// every manual range, single short conversion, zeroing on odd codes
		for (int r = 0; r < 12; r++) begin
			rv = 4'(r);
			cfg = {rv, 4'h2, 5'h00, rv[0], 2'h0};
			adc_mantissa = {rv, 8'h5a};
			light_host_inst.wr16(light_pkg::PTR_SETUP, cfg);
			rd_chk(light_pkg::PTR_SETUP, cfg);
			check({12'h0, range_out}, {12'h0, rv});
			wait_conv(1'b0, 40);
			rd_chk(light_pkg::PTR_RESULT, {rv[0] ? 4'h0 : rv, adc_mantissa});
			rd_chk(light_pkg::PTR_SETUP, (cfg & 16'hf9ff) | 16'h0080);
		end
		// auto range stepping up to code 3 with zeroing set
		adc_overload = 1'b1;
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'hc204);
		n = 0;
		while (range_out !== 4'h3 && n < 100) begin
			@(posedge clk) #1;
			n++;
		end
		adc_overload = 1'b0;
		wait_conv(1'b0, 40);
		rd_chk(light_pkg::PTR_RESULT, {4'h3, adc_mantissa});
		rd_chk(light_pkg::PTR_SETUP, 16'hc084);
		// overload through every range
		adc_overload = 1'b1;
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'hc204);
		wait_conv(1'b1, 10);
		wait_conv(1'b0, 200);
		adc_overload = 1'b0;
		rd_chk(light_pkg::PTR_RESULT, 16'hbfff);
		rd_chk(light_pkg::PTR_SETUP, 16'hc184);
		// continuous restart, then a shutdown write aborts
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'h1600);
		wait_conv(1'b1, 10);
		wait_conv(1'b0, 20);
		wait_conv(1'b1, 4);
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'h1000);
		wait_conv(1'b0, 4);
		repeat (30) @(posedge clk);
		check({15'h0, converting}, 16'h0000);
		rd_chk(light_pkg::PTR_SETUP, 16'h1080);
		// long single conversion, busy cycles counted
		light_host_inst.wr16(light_pkg::PTR_SETUP, 16'h0a00);
		wait_conv(1'b1, 10);
		n = 0;
		while (converting === 1'b1 && n < 100) begin
			@(posedge clk) #1;
			n++;
		end
		check(16'(n), 16'(LONG_T));
		print_verdict();
	end
endmodule

// file: common/light_pkg.sv
// shared constants for the light result and setup register block
package light_pkg;
	// register pointers
	localparam logic [7:0]  PTR_RESULT   = 8'h00;
	localparam logic [7:0]  PTR_SETUP    = 8'h01;
	// operation_setup layout
	localparam logic [15:0] SETUP_RESET  = 16'hc810;
	localparam int          RANGE_MSB    = 15;
	localparam int          RANGE_LSB    = 12;
	localparam int          DUR_BIT      = 11;
	localparam int          MODE_MSB     = 10;
	localparam int          MODE_LSB     = 9;
	localparam int          OVF_BIT      = 8;
	localparam int          CRF_BIT      = 7;
	localparam int          ZERO_EN_BIT  = 2;
	// host-writable bits: 15..9 and 4..0
	localparam logic [15:0] SETUP_RW     = 16'hfe1f;
	// light_result layout
	localparam int          EXP_MSB      = 15;
	localparam int          EXP_LSB      = 12;
	localparam int          MANT_W       = 12;
	// range codes
	localparam logic [3:0]  RANGE_MAX    = 4'hb;
	localparam logic [3:0]  RANGE_AUTO   = 4'hc;
	localparam logic [3:0]  RANGE_LOW    = 4'h0;
	localparam logic [11:0] MANT_FULL    = 12'hfff;
	// conversion modes
	localparam logic [1:0]  MODE_OFF     = 2'h0;
	localparam logic [1:0]  MODE_SINGLE  = 2'h1;
	// conversion durations
	localparam int          CLK_KHZ      = 125000;
	localparam int          DUR_SHORT_MS = 100;
	localparam int          DUR_LONG_MS  = 800;
	localparam int          SHORT_CYC    = DUR_SHORT_MS * CLK_KHZ;
	localparam int          LONG_CYC     = DUR_LONG_MS * CLK_KHZ;
	localparam int          CNT_W        = 27;
endpackage

// file: core/conv_engine.sv
// conversion timer with automatic range stepping
`timescale 1ns/1ps
module conv_engine #(
	parameter int SHORT_CYCLES = light_pkg::SHORT_CYC,
	parameter int LONG_CYCLES  = light_pkg::LONG_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// control
	input  wire logic        start,
	input  wire logic        abort,
	input  wire logic        long_sel,
	input  wire logic [3:0]  range_sel,
	// analog front end
	input  wire logic [11:0] mantissa,
	input  wire logic        overload,
	// outputs
	output logic             busy,
	output logic             done,
	output logic [3:0]       range_now,
	output logic [15:0]      result,
	output logic             ovf
);
	typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CONV = 1'b1} st_t;
	typedef struct packed {
		st_t                        st;
		logic [light_pkg::CNT_W-1:0] cnt;
		logic [3:0]                 range;
		logic                       done;
		logic [15:0]                result;
		logic                       ovf;
	} eng_t;

	eng_t r_reg, r_next;
	logic                        auto_mode;
	logic [light_pkg::CNT_W-1:0] limit;

	// range codes at or above the auto code select automatic ranging
	assign auto_mode = (range_sel >= light_pkg::RANGE_AUTO); // [RULE8]
	assign limit = long_sel ? light_pkg::CNT_W'(LONG_CYCLES - 1)
	                        : light_pkg::CNT_W'(SHORT_CYCLES - 1); // [RULE14]

	// next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.done = 1'b0;
		if (abort) begin
			r_next.st = ST_IDLE; // [RULE5]
		end
		if (start) begin
			r_next.st = ST_CONV; // [RULE6]
			r_next.cnt = limit;
			r_next.range = auto_mode ? light_pkg::RANGE_LOW : range_sel; // [RULE7]
		end else if (!abort && r_reg.st == ST_CONV) begin
			if (r_reg.cnt != '0) begin
				r_next.cnt = r_reg.cnt - 1'b1;
			end else if (auto_mode && overload && r_reg.range < light_pkg::RANGE_MAX) begin // [RULE2]
				r_next.range = r_reg.range + 1'b1; // [RULE8]
				r_next.cnt = limit;
			end else begin
				r_next.st = ST_IDLE;
				r_next.done = 1'b1;
				r_next.ovf = overload;
				r_next.result = {r_reg.range,
				                 overload ? light_pkg::MANT_FULL : mantissa}; // [RULE1] [RULE3]
			end
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			r_reg <= '{st: ST_IDLE, cnt: '0, range: light_pkg::RANGE_LOW, done: 1'b0,
			           result: '0, ovf: 1'b0};
		end else begin
			r_reg <= r_next;
		end
	end

	assign busy      = (r_reg.st == ST_CONV);
	assign done      = r_reg.done;
	assign range_now = r_reg.range;
	assign result    = r_reg.result;
	assign ovf       = r_reg.ovf;
endmodule

// file: core/light_regs.sv
// result and setup registers with byte-wide register port
`timescale 1ns/1ps
// Function
// (RULE1) result word: exponent in bits 15:12, mantissa in bits 11:0
// (RULE2) exponent codes 0..11 give weight 0.01 lux times two to the code
// (RULE3) mantissa is unsigned binary from zero to full scale
// (RULE4) zeroing enabled with manual range reports exponent as zero
// (RULE5) any setup register write aborts a running conversion
// (RULE6) after that write a conversion starts if the new mode asks
// (RULE7) range select bits 15:12 pick full scale, same codes as exponent
// (RULE8) range code 1100b ranges automatically, chosen range shown in exponent
// (RULE9) range select resets to 1100b, automatic ranging
// (RULE10) host never writes reserved range codes 1101b to 1111b
// (RULE11) the whole result register is read-only
// (RULE12) setup bits 8:5 are status; 15:9 and 4:0 read/write
// (RULE13) host writes to status bit positions are ignored
// (RULE14) duration bit: 0 is 100 ms, 1 is 800 ms, reset 1
// (RULE15) mode: 00 off, 01 single, 1x continuous, reset 00
// (RULE16) single conversion reads 01 while running, then mode returns to 00
// (RULE17) registers move as two bytes, most significant byte first
module light_regs #(
	parameter int SHORT_CYCLES = light_pkg::SHORT_CYC,
	parameter int LONG_CYCLES  = light_pkg::LONG_CYC
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	// register port
	input  wire logic        PTR_WR,
	input  wire logic [7:0]  PTR_DATA,
	input  wire logic        WR_STB,
	input  wire logic [7:0]  WR_DATA,
	input  wire logic        RD_STB,
	output logic      [7:0]  RD_DATA,
	output logic             RD_VALID,
	// analog front end
	input  wire logic [11:0] ADC_MANTISSA,
	input  wire logic        ADC_OVERLOAD,
	output logic      [3:0]  RANGE_OUT,
	output logic             CONVERTING
);
	typedef struct packed {
		logic [15:0] setup;
		logic [7:0]  ptr;
		logic        wr_phase;
		logic [7:0]  wr_hold;
		logic        rd_phase;
		logic [7:0]  rd_hold;
		logic [7:0]  rd_byte;
		logic        rd_valid;
		logic        start;
		logic        abort;
		logic [3:0]  range_out;
		logic        converting;
	} regs_t;

	regs_t       r_reg, r_next;
	logic        busy, done, eng_ovf;
	logic [3:0]  range_now;
	logic [15:0] eng_result;
	logic        commit;
	logic        setup_wr;
	logic [15:0] wr_word;

	// read value of a register, exponent masked where zeroing applies
	function automatic logic [15:0] reg_value(input logic [7:0] p, input logic [15:0] s,
	                                          input logic [15:0] res);
		logic [15:0] v;
		v = '0;
		if (p == light_pkg::PTR_RESULT) begin
			v = res;
			if (s[light_pkg::ZERO_EN_BIT] &&
			    s[light_pkg::RANGE_MSB:light_pkg::RANGE_LSB] < light_pkg::RANGE_AUTO) begin
				v[light_pkg::EXP_MSB:light_pkg::EXP_LSB] = '0; // [RULE4]
			end
		end else if (p == light_pkg::PTR_SETUP) begin
			v = s;
		end
		return v;
	endfunction

	conv_engine #(
		.SHORT_CYCLES(SHORT_CYCLES),
		.LONG_CYCLES (LONG_CYCLES)
	) u_engine (
		.clk      (CLK),
		.reset_n  (RESET_N),
		.start    (r_reg.start),
		.abort    (r_reg.abort),
		.long_sel (r_reg.setup[light_pkg::DUR_BIT]),
		.range_sel(r_reg.setup[light_pkg::RANGE_MSB:light_pkg::RANGE_LSB]),
		.mantissa (ADC_MANTISSA),
		.overload (ADC_OVERLOAD),
		.busy     (busy),
		.done     (done),
		.range_now(range_now),
		.result   (eng_result),
		.ovf      (eng_ovf)
	);

	// second byte commits; a pointer load in the same cycle wins
	assign commit   = WR_STB && !PTR_WR && r_reg.wr_phase;
	assign setup_wr = commit && (r_reg.ptr == light_pkg::PTR_SETUP);
	assign wr_word  = {r_reg.wr_hold, WR_DATA}; // [RULE17]

	// next-state logic
	always_comb begin
		r_next = r_reg;
		r_next.start = 1'b0;
		r_next.abort = 1'b0;
		r_next.rd_valid = 1'b0;
		r_next.range_out = range_now;
		r_next.converting = busy;
		// pointer load restarts the byte sequence
		if (PTR_WR) begin
			r_next.ptr = PTR_DATA;
			r_next.wr_phase = 1'b0;
			r_next.rd_phase = 1'b0;
		end else if (WR_STB) begin
			r_next.wr_phase = !r_reg.wr_phase;
			r_next.wr_hold = WR_DATA; // [RULE17]
		end
		// second byte commits; result pointer ignores writes
		if (commit && r_reg.ptr == light_pkg::PTR_SETUP) begin
			r_next.setup = (wr_word & light_pkg::SETUP_RW) |
			               (r_reg.setup & ~light_pkg::SETUP_RW); // [RULE12] [RULE13] [RULE11]
			r_next.abort = 1'b1; // [RULE5]
			r_next.start = (wr_word[light_pkg::MODE_MSB:light_pkg::MODE_LSB]
			                != light_pkg::MODE_OFF); // [RULE6] [RULE15]
		end
		// reads: snapshot the word, MSB now, LSB on the next strobe
		if (RD_STB && !PTR_WR) begin
			r_next.rd_valid = 1'b1;
			r_next.rd_phase = !r_reg.rd_phase;
			if (!r_reg.rd_phase) begin
				{r_next.rd_byte, r_next.rd_hold} =
					reg_value(r_reg.ptr, r_reg.setup, eng_result); // [RULE17]
				if (r_reg.ptr == light_pkg::PTR_SETUP) begin
					r_next.setup[light_pkg::CRF_BIT] = 1'b0;
				end
			end else begin
				r_next.rd_byte = r_reg.rd_hold;
			end
		end
		// conversion finished: status always, mode follow-up unless a setup write lands
		if (done) begin
			r_next.setup[light_pkg::CRF_BIT] = 1'b1; // set wins over read clear and write
			r_next.setup[light_pkg::OVF_BIT] = eng_ovf;
			if (!setup_wr) begin
				if (r_reg.setup[light_pkg::MODE_MSB:light_pkg::MODE_LSB] == light_pkg::MODE_SINGLE) begin
					r_next.setup[light_pkg::MODE_MSB:light_pkg::MODE_LSB] = light_pkg::MODE_OFF; // [RULE16]
				end else if (r_reg.setup[light_pkg::MODE_MSB]) begin
					r_next.start = 1'b1; // [RULE15]
				end
			end
		end
	end

	// state register
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			r_reg <= '0;
			r_reg.setup <= light_pkg::SETUP_RESET; // [RULE9] [RULE14] [RULE15]
		end else begin
			r_reg <= r_next;
		end
	end

	assign RD_DATA    = r_reg.rd_byte;
	assign RD_VALID   = r_reg.rd_valid;
	assign RANGE_OUT  = r_reg.range_out;
	assign CONVERTING = r_reg.converting;

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	a_setup_reset: assert property (disable iff (1'b0) // [RULE9]
		!RESET_N |=> r_reg.setup == light_pkg::SETUP_RESET)
		else $error("setup register reset value wrong");
	a_write_abort: assert property (setup_wr // [RULE5]
		|=> r_reg.abort ##1 busy == $past(r_reg.start))
		else $error("setup write did not abort conversion");
	a_write_start: assert property (setup_wr // [RULE6]
		&& wr_word[light_pkg::MODE_MSB:light_pkg::MODE_LSB] != light_pkg::MODE_OFF
		|=> r_reg.start ##1 busy)
		else $error("setup write with mode did not start conversion");
	a_status_kept: assert property (commit && !done // [RULE13]
		|=> r_reg.setup[light_pkg::OVF_BIT] == $past(r_reg.setup[light_pkg::OVF_BIT]))
		else $error("host write changed status bit");
	a_single_off: assert property (done && !commit // [RULE16]
		&& r_reg.setup[light_pkg::MODE_MSB:light_pkg::MODE_LSB] == light_pkg::MODE_SINGLE
		|=> r_reg.setup[light_pkg::MODE_MSB:light_pkg::MODE_LSB] == light_pkg::MODE_OFF
		&& !r_reg.start)
		else $error("single conversion did not return mode to off");
	a_crf_set: assert property (done |=> r_reg.setup[light_pkg::CRF_BIT]) // [RULE12]
		else $error("conversion ready not set");
	a_msb_first: assert property (RD_STB && !PTR_WR && !r_reg.rd_phase // [RULE17]
		&& r_reg.ptr == light_pkg::PTR_SETUP
		|=> RD_VALID && RD_DATA == $past(r_reg.setup[light_pkg::RANGE_MSB -: 8]))
		else $error("first read byte is not the high byte");
	a_exp_zeroed: assert property (RD_STB && !PTR_WR && !r_reg.rd_phase // [RULE4]
		&& r_reg.ptr == light_pkg::PTR_RESULT && r_reg.setup[light_pkg::ZERO_EN_BIT]
		&& r_reg.setup[light_pkg::RANGE_MSB:light_pkg::RANGE_LSB] < light_pkg::RANGE_AUTO
		|=> RD_DATA[7:4] == 4'h0)
		else $error("exponent not zeroed in manual range");
	a_result_ro: assert property (commit && r_reg.ptr == light_pkg::PTR_RESULT // [RULE11]
		|=> (!r_reg.abort && r_reg.setup == $past(r_reg.setup)) || $past(done))
		else $error("write to result register had an effect");

	c_single_done: cover property (r_reg.setup[10:9] == 2'b01 && done);
	c_cont_restart: cover property (r_reg.setup[10] && done ##1 r_reg.start);
	c_auto_step: cover property (busy && r_reg.setup[15:12] == 4'hc ##1 $changed(range_now) && busy);
endmodule
